// file: hw/pss_top.sv
/*
  Supply selection, ON/OFF state machine, standby and wake sequencing.
  Assumes rstn marks the first application of power; pins are asynchronous to core_clk.
*/
// What this block does
// - Prefer bus supply, never both switches on
// - Bus supply forces ON, button ignored
// - Start OFF; only button or bus supply leaves OFF
// - Button low for debounce turns ON
// - OFF to ON: logic supply, power-on reset
// - Long press in ON latches shutdown request
// - Shutdown bit: deactivate card, then power off
// - Shutdown bit accepted anytime without bus supply
// - Grounded button powers up with any supply
// - Bus removal in ON: battery, stay ON
// - Bus supply, no card supply: bypass boost
// - Standby halts core, clocks and peripherals
// - Power-down while ON or bus: standby
// - Power-down while OFF, no bus: converter off
// - Analog shutdown 32 clocks after power-down
// - Sources 0, 4, 5 ORed into wake
// - Wake: restore, 512 clocks, then interrupt 0
// - Reading wake control clears wake routing
// - Power-down overrides individual power controls
`include "pss_cfg.svh"
module pss_top #(
  parameter int DEBOUNCE_CYC = `PSS_DEBOUNCE_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output wire logic [7:0]  reg_rdata,
  input  wire logic        on_off_n,
  input  wire logic        bus_supply,
  input  wire logic        battery_supply,
  input  wire logic        primary_supply,
  input  wire logic        irq_user_port_pins,
  input  wire logic        irq_card,
  input  wire logic        irq_keypad,
  input  wire logic        card_active,
  output wire logic        bus_switch_en,
  output wire logic        battery_switch_en,
  output wire logic        logic_supply_en,
  output wire logic        por_active,
  output wire logic        converter_en,
  output wire logic        boost_bypass,
  output wire logic        analog_en,
  output wire logic        core_clk_gate,
  output wire logic        periph_power_off,
  output wire logic        card_clk_off,
  output wire logic        keypad_clk_off,
  output wire logic        card_deactivate,
  output wire logic        shutdown_req,
  output wire logic        ext_interrupt_zero
);
  pss_pkg::pss_top_st_t q_ff;
  pss_pkg::pss_top_st_t nxt_q;

  pss_tmr_if db_if ();
  pss_tmr_if pd_if ();
  pss_tmr_if wk_if ();

  logic pd_start;
  logic wk_start;

  pss_debounce #(
    .CYC (DEBOUNCE_CYC)
  ) u_debounce (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tmr      (db_if.tmr)
  );

  pss_delay #(
    .CYC (`PSS_PD_DLY_CYC)
  ) u_pd_delay (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tmr      (pd_if.tmr)
  );

  pss_delay #(
    .CYC (`PSS_WAKE_DLY_CYC)
  ) u_wake_delay (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tmr      (wk_if.tmr)
  );

  // Synchronised pin levels
  logic btn;
  logic bus;
  logic bat;
  logic prim;
  logic irq_usr;
  logic irq_crd;
  logic irq_kp;
  logic any_supply;
  logic held_rise;
  logic wake_req;
  logic pd_active;

  assign btn        = ~q_ff.s2[`PSS_IN_BTN_N];
  assign bus        = q_ff.s2[`PSS_IN_BUS];
  assign bat        = q_ff.s2[`PSS_IN_BAT];
  assign prim       = q_ff.s2[`PSS_IN_PRIM];
  assign irq_usr    = q_ff.s2[`PSS_IN_USR];
  assign irq_crd    = q_ff.s2[`PSS_IN_CARD];
  assign irq_kp     = q_ff.s2[`PSS_IN_KP];
  assign any_supply = bus | bat | prim;
  assign held_rise  = db_if.expired & ~q_ff.held_d;
  assign pd_active  = (q_ff.st == pss_pkg::ST_PD_DLY) || (q_ff.st == pss_pkg::ST_STANDBY);

  // Wake only through routed sources
  assign wake_req = q_ff.route & (irq_usr | irq_crd | irq_kp);

  // Press only counts with some supply present
  assign db_if.arm = btn & any_supply;
  assign pd_if.arm = pd_start;
  assign wk_if.arm = wk_start;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction

  logic wr_wake;
  logic wr_misc0;
  logic wr_card;
  logic rd_wake;

  assign wr_wake  = reg_we & hit(reg_addr, `PSS_ADDR_WAKE_CTL);
  assign wr_misc0 = reg_we & hit(reg_addr, `PSS_ADDR_MISC0);
  assign wr_card  = reg_we & hit(reg_addr, `PSS_ADDR_CARD_CTL);
  assign rd_wake  = reg_re & hit(reg_addr, `PSS_ADDR_WAKE_CTL);

  always_comb begin
    nxt_q    = q_ff;
    pd_start = 1'b0;
    wk_start = 1'b0;

    nxt_q.s1     = {irq_keypad, irq_card, irq_user_port_pins, primary_supply,
                    battery_supply, bus_supply, on_off_n};
    nxt_q.s2     = q_ff.s1;
    nxt_q.held_d = db_if.expired;

    // One switch must open before the other closes
    nxt_q.sel_bus = bus & ~q_ff.sel_bat;
    nxt_q.sel_bat = bat & ~bus & ~q_ff.sel_bus;

    // Register writes
    if (wr_wake) begin
      nxt_q.route  = reg_wdata[`PSS_WAKE_ROUTE_BIT];
      nxt_q.kp_ien = reg_wdata[`PSS_WAKE_KPIEN_BIT];
    end else if (rd_wake) begin
      nxt_q.route = 1'b0;
    end
    if (wr_misc0) begin
      nxt_q.card_ck_off = reg_wdata[`PSS_MISC0_CARDCK_BIT];
      nxt_q.kp_ck_off   = reg_wdata[`PSS_MISC0_KPCK_BIT];
    end
    if (wr_card) begin
      nxt_q.card_req = reg_wdata[`PSS_CARD_REQ_BIT];
      // Ignored while the bus supply holds the device ON
      if (reg_wdata[`PSS_CARD_SHDN_BIT] && !bus) begin
        nxt_q.shdn_pend = 1'b1;
      end
    end
    if (rd_wake) begin
      nxt_q.wake_pend = 1'b0;
    end

    unique case (q_ff.st)
      pss_pkg::ST_OFF: begin
        nxt_q.por_cnt = '0;
        if (bus || (db_if.expired && any_supply)) begin
          nxt_q.st = pss_pkg::ST_POR;
        end
      end
      pss_pkg::ST_POR: begin
        // Logic supply up, reset held
        nxt_q.por_cnt = q_ff.por_cnt + 1'b1;
        if (q_ff.por_cnt == 4'(`PSS_POR_CYC - 1)) begin
          nxt_q.st = pss_pkg::ST_ON;
        end
      end
      pss_pkg::ST_ON: begin
        if (!bus && held_rise) begin
          nxt_q.shdn_req = 1'b1;
        end
        if (nxt_q.shdn_pend && !bus) begin
          nxt_q.st = pss_pkg::ST_CARD_OFF;
        end else if (wr_misc0 && reg_wdata[`PSS_MISC0_PD_BIT]) begin
          nxt_q.st = pss_pkg::ST_PD_DLY;
          pd_start = 1'b1;
        end
      end
      pss_pkg::ST_CARD_OFF: begin
        if (!card_active) begin
          nxt_q.st = pss_pkg::ST_OFF;
        end
      end
      pss_pkg::ST_PD_DLY: begin
        if (pd_if.expired) begin
          // Pending switch request means the ON/OFF logic wants OFF
          if (bus || !q_ff.shdn_req) begin
            nxt_q.st = pss_pkg::ST_STANDBY;
          end else begin
            nxt_q.st = pss_pkg::ST_OFF;
          end
        end
      end
      pss_pkg::ST_STANDBY: begin
        if (wake_req) begin
          nxt_q.st = pss_pkg::ST_WAKE_DLY;
          wk_start = 1'b1;
        end
      end
      pss_pkg::ST_WAKE_DLY: begin
        if (wk_if.expired) begin
          nxt_q.st        = pss_pkg::ST_ON;
          nxt_q.wake_pend = 1'b1;
        end
      end
      // Spare state code: fall back to the safe OFF state
      default: begin
        nxt_q.st = pss_pkg::ST_OFF;
      end
    endcase

    // Logic supply gone: all firmware-visible state returns to reset
    if (nxt_q.st == pss_pkg::ST_OFF) begin
      nxt_q.shdn_req    = 1'b0;
      nxt_q.shdn_pend   = 1'b0;
      nxt_q.route       = 1'b0;
      nxt_q.kp_ien      = 1'b0;
      nxt_q.card_ck_off = 1'b0;
      nxt_q.kp_ck_off   = 1'b0;
      nxt_q.card_req    = 1'b0;
      nxt_q.wake_pend   = 1'b0;
    end

    // Read data valid only in the cycle after the strobe
    nxt_q.rdata = 8'h00;
    if (reg_re) begin
      if (hit(reg_addr, `PSS_ADDR_WAKE_CTL)) begin
        nxt_q.rdata[`PSS_WAKE_ROUTE_BIT] = q_ff.route;
        nxt_q.rdata[`PSS_WAKE_KPIEN_BIT] = q_ff.kp_ien;
        nxt_q.rdata[`PSS_WAKE_KPFLG_BIT] = irq_kp;
      end else if (hit(reg_addr, `PSS_ADDR_MISC0)) begin
        nxt_q.rdata[`PSS_MISC0_PD_BIT]     = pd_active;
        nxt_q.rdata[`PSS_MISC0_CARDCK_BIT] = q_ff.card_ck_off;
        nxt_q.rdata[`PSS_MISC0_KPCK_BIT]   = q_ff.kp_ck_off;
      end else if (hit(reg_addr, `PSS_ADDR_CARD_CTL)) begin
        nxt_q.rdata[`PSS_CARD_REQ_BIT]  = q_ff.card_req;
        nxt_q.rdata[`PSS_CARD_SHDN_BIT] = q_ff.shdn_pend;
      end else if (hit(reg_addr, `PSS_ADDR_STATUS)) begin
        nxt_q.rdata = {2'b00, q_ff.wake_pend, (q_ff.st == pss_pkg::ST_STANDBY),
                       q_ff.sel_bat, q_ff.sel_bus, q_ff.shdn_req,
                       (q_ff.st != pss_pkg::ST_OFF)};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q_ff    <= '0;
      q_ff.st <= pss_pkg::ST_OFF;
      // Button synchroniser starts at the released level
      q_ff.s1[`PSS_IN_BTN_N] <= 1'b1;
      q_ff.s2[`PSS_IN_BTN_N] <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign reg_rdata         = q_ff.rdata;
  assign bus_switch_en     = q_ff.sel_bus;
  assign battery_switch_en = q_ff.sel_bat;
  assign logic_supply_en   = (q_ff.st != pss_pkg::ST_OFF);
  assign por_active        = (q_ff.st == pss_pkg::ST_POR) || (q_ff.st == pss_pkg::ST_OFF);
  assign converter_en      = (q_ff.st != pss_pkg::ST_OFF);
  assign boost_bypass      = q_ff.sel_bus & ~q_ff.card_req & converter_en;
  assign analog_en         = (q_ff.st != pss_pkg::ST_OFF) && (q_ff.st != pss_pkg::ST_STANDBY);
  assign core_clk_gate     = (q_ff.st == pss_pkg::ST_STANDBY);
  assign periph_power_off  = (q_ff.st == pss_pkg::ST_STANDBY);
  assign card_clk_off      = q_ff.card_ck_off | pd_active;
  assign keypad_clk_off    = q_ff.kp_ck_off | pd_active;
  assign card_deactivate   = (q_ff.st == pss_pkg::ST_CARD_OFF);
  assign shutdown_req      = q_ff.shdn_req;
  assign ext_interrupt_zero = irq_usr | q_ff.wake_pend;
endmodule // pss_top

// file: hw/pss_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the power sequencer.
  Assumes a single 50 MHz core clock and 8-bit registers on a 16-bit address.
*/
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

`define PSS_CLK_MHZ          50
`define PSS_DEBOUNCE_US      50000
`define PSS_DEBOUNCE_CYC     (`PSS_DEBOUNCE_US * `PSS_CLK_MHZ)
`define PSS_PD_DLY_CYC       32
`define PSS_WAKE_DLY_CYC     512
`define PSS_POR_CYC          16

`define PSS_ADDR_WAKE_CTL    16'hff94
`define PSS_ADDR_MISC0       16'hfff1
`define PSS_ADDR_CARD_CTL    16'hfe00
`define PSS_ADDR_STATUS      16'hfe01

`define PSS_WAKE_ROUTE_BIT   7
`define PSS_WAKE_KPIEN_BIT   1
`define PSS_WAKE_KPFLG_BIT   0
`define PSS_MISC0_PD_BIT     7
`define PSS_MISC0_CARDCK_BIT 1
`define PSS_MISC0_KPCK_BIT   0
`define PSS_CARD_REQ_BIT     0
`define PSS_CARD_SHDN_BIT    1

`define PSS_WAKE_CTL_RST     8'h00
`define PSS_MISC0_RST        8'h00
`define PSS_CARD_CTL_RST     8'h00

`define PSS_IN_BTN_N         0
`define PSS_IN_BUS           1
`define PSS_IN_BAT           2
`define PSS_IN_PRIM          3
`define PSS_IN_USR           4
`define PSS_IN_CARD          5
`define PSS_IN_KP            6
`define PSS_IN_NUM           7

`endif

// file: hw/pss_pkg.sv
/*
  Types of the power sequencer.
  Assumes pss_cfg.svh is compiled in the same unit.
*/
`include "pss_cfg.svh"
package pss_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_POR,
    ST_ON,
    ST_CARD_OFF,
    ST_PD_DLY,
    ST_STANDBY,
    ST_WAKE_DLY
  } pss_state_t;

  typedef struct packed {
    logic [`PSS_IN_NUM-1:0] s1;
    logic [`PSS_IN_NUM-1:0] s2;
    pss_state_t             st;
    logic [3:0]             por_cnt;
    logic                   sel_bus;
    logic                   sel_bat;
    logic                   held_d;
    logic                   shdn_req;
    logic                   route;
    logic                   kp_ien;
    logic                   card_ck_off;
    logic                   kp_ck_off;
    logic                   card_req;
    logic                   shdn_pend;
    logic                   wake_pend;
    logic [7:0]             rdata;
  } pss_top_st_t;
endpackage

// file: hw/pss_tmr_if.sv
/*
  Arm/expiry pair between the sequencer and its timers.
  Assumes the controller drives arm on the core clock.
*/
interface pss_tmr_if;
  logic arm;
  logic expired;
  modport ctrl (output arm, input expired);
  modport tmr (input arm, output expired);
endinterface

// file: hw/pss_debounce.sv
/*
  Hold timer for the ON/OFF button: expired rises once arm has stayed high CYC cycles.
  Assumes arm is already synchronised to core_clk.
*/
`include "pss_cfg.svh"
module pss_debounce #(
  parameter int CYC = `PSS_DEBOUNCE_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  pss_tmr_if.tmr   tmr
);
  localparam int W = $clog2(CYC + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
  } pss_db_st_t;

  pss_db_st_t q_ff;
  pss_db_st_t nxt_q;

  always_comb begin
    nxt_q = q_ff;
    // Any release restarts the hold
    if (!tmr.arm) begin
      nxt_q.cnt = '0;
    end else if (q_ff.cnt != W'(CYC)) begin
      nxt_q.cnt = q_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign tmr.expired = (q_ff.cnt == W'(CYC));
endmodule // pss_debounce

// file: hw/pss_delay.sv
/*
  One-shot delay: a pulse on arm loads CYC, expired pulses for one cycle CYC-1 edges later.
  Assumes arm is a one-cycle pulse from logic on core_clk.
*/
`include "pss_cfg.svh"
module pss_delay #(
  parameter int CYC = `PSS_PD_DLY_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  pss_tmr_if.tmr   tmr
);
  localparam int W = $clog2(CYC + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
  } pss_dly_st_t;

  pss_dly_st_t q_ff;
  pss_dly_st_t nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (tmr.arm) begin
      nxt_q.cnt = W'(CYC);
    end else if (q_ff.cnt != '0) begin
      nxt_q.cnt = q_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign tmr.expired = (q_ff.cnt == W'(1));
endmodule // pss_delay

// file: verif/pss_top_chk.sv
/*
  Concurrent checks on the ports of the power sequencer top.
  Assumes pss_cfg.svh is compiled alongside and a single core_clk domain.
*/
`include "pss_cfg.svh"
module pss_top_chk (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_we,
  input wire logic        bus_supply,
  input wire logic        bus_switch_en,
  input wire logic        battery_switch_en,
  input wire logic        logic_supply_en,
  input wire logic        por_active,
  input wire logic        analog_en,
  input wire logic        core_clk_gate,
  input wire logic        periph_power_off,
  input wire logic        keypad_clk_off,
  input wire logic        card_deactivate,
  input wire logic        shutdown_req,
  input wire logic        ext_interrupt_zero
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic        gate_q_ff;
  logic [10:0] wk_cnt_ff;

  // Cycles since standby ended, zero when idle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gate_q_ff <= 1'b0;
      wk_cnt_ff <= 11'h000;
    end else begin
      gate_q_ff <= core_clk_gate;
      if (gate_q_ff && !core_clk_gate && logic_supply_en) wk_cnt_ff <= 11'h001;
      else if (wk_cnt_ff != 11'h000 && !ext_interrupt_zero) wk_cnt_ff <= wk_cnt_ff + 11'h001;
      else wk_cnt_ff <= 11'h000;
    end
  end

  sequence pd_write_s;
    reg_we && reg_addr == `PSS_ADDR_MISC0 && reg_wdata[`PSS_MISC0_PD_BIT] && logic_supply_en && !por_active;
  endsequence
  sequence analog_stop_s;
    analog_en ##1 !analog_en;
  endsequence

  no_both_on_a: assert property (!(bus_switch_en && battery_switch_en))
    else $error("both supply switches on");
  bus_forces_on_a: assert property ($rose(bus_supply) |-> ##[1:6] logic_supply_en)
    else $error("bus supply did not force on");
  por_hold_a: assert property ($rose(logic_supply_en) |-> por_active[*8] ##1 por_active[*8] ##1 !por_active)
    else $error("power-on reset length wrong");
  shdn_hold_a: assert property (shutdown_req |=> shutdown_req || !logic_supply_en)
    else $error("shutdown request dropped while on");
  shdn_clear_a: assert property ($rose(logic_supply_en) |-> !shutdown_req)
    else $error("shutdown request survived power cycle");
  card_off_a: assert property (card_deactivate |-> ##[1:8] !logic_supply_en)
    else $error("logic supply stayed on after card shutdown");
  bus_drop_a: assert property ($fell(bus_supply) && logic_supply_en && !por_active |-> logic_supply_en[*8])
    else $error("bus removal left on state");
  standby_halt_a: assert property (core_clk_gate |-> periph_power_off && !analog_en && keypad_clk_off)
    else $error("standby left something running");
  pd_delay_a: assert property (pd_write_s ##1 keypad_clk_off |-> ##31 analog_stop_s)
    else $error("analog shutdown delay wrong");
  wake_delay_a: assert property (wk_cnt_ff != 11'h000 |-> ext_interrupt_zero == (wk_cnt_ff == 11'h200))
    else $error("wake interrupt delay wrong");
endmodule // pss_top_chk

bind pss_top pss_top_chk u_chk (
  .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .bus_supply(bus_supply), .bus_switch_en(bus_switch_en), .battery_switch_en(battery_switch_en),
  .logic_supply_en(logic_supply_en), .por_active(por_active), .analog_en(analog_en),
  .core_clk_gate(core_clk_gate), .periph_power_off(periph_power_off), .keypad_clk_off(keypad_clk_off),
  .card_deactivate(card_deactivate), .shutdown_req(shutdown_req), .ext_interrupt_zero(ext_interrupt_zero)
);

// file: verif/pss_btn_model.sv
/*
  Momentary push-button to ground: the contact chatters for three cycles on every change.
  Assumes press is a level from the bench, high while the button is held.
*/
module pss_btn_model (
  input  wire logic core_clk,
  input  wire logic press,
  output logic      on_off_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] bounce_ff;
  logic       press_q_ff;

  initial begin
    bounce_ff = 2'h0;
    press_q_ff = 1'b0;
    on_off_n = 1'b1;
  end

  // Contact chatter before the pin settles
  always @(posedge core_clk) begin
    press_q_ff <= press;
    if (press != press_q_ff) bounce_ff <= 2'h3;
    else if (bounce_ff != 2'h0) bounce_ff <= bounce_ff - 2'h1;
    on_off_n <= (bounce_ff != 2'h0) ? ~on_off_n : ~press;
  end
endmodule // pss_btn_model

// file: verif/pss_top_tb.sv
/*
  Self-checking bench of the power sequencer top with a chattering button model.
  Assumes a shortened debounce count and the register map of pss_cfg.svh.
*/
`include "pss_cfg.svh"
module pss_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rstn, reg_we, reg_re, press, on_off_n, card_active;
  logic        bus_supply, battery_supply, primary_supply;
  logic [2:0]  irq;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        bus_sw, bat_sw, lse, por, conv, byp, ana, gate, pwr_off, card_ck, kp_ck, card_dea, shdn, eint;
  int          mismatches, check_count, seed, n;

  pss_btn_model u_btn (.core_clk(core_clk), .press(press), .on_off_n(on_off_n));
  pss_top #(.DEBOUNCE_CYC(20)) dut (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .on_off_n(on_off_n), .bus_supply(bus_supply),
    .battery_supply(battery_supply), .primary_supply(primary_supply), .irq_user_port_pins(irq[0]),
    .irq_card(irq[1]), .irq_keypad(irq[2]), .card_active(card_active), .bus_switch_en(bus_sw),
    .battery_switch_en(bat_sw), .logic_supply_en(lse), .por_active(por), .converter_en(conv),
    .boost_bypass(byp), .analog_en(ana), .core_clk_gate(gate), .periph_power_off(pwr_off),
    .card_clk_off(card_ck), .keypad_clk_off(kp_ck), .card_deactivate(card_dea), .shutdown_req(shdn),
    .ext_interrupt_zero(eint));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [7:0] stat(input logic on, sd, sb, sa, sby, wp);
    return {2'h0, wp, sby, sa, sb, sd, on};
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic wait_on(ref logic s, input logic v, input int lim);
    int i;
    i = 0;
    while (s !== v && i < lim) begin
      @(posedge core_clk);
      i++;
    end
    if (s !== v) begin
      mismatches++;
      $display("unexpected at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp, what);
  endtask

  initial begin
    seed = 32'hcd67;
    {rstn, reg_we, reg_re, press, card_active, bus_supply, primary_supply, irq} = '0;
    battery_supply = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    mismatches = 0;
    check_count = 0;
    cyc(20);
    rstn <= 1'b1;
    cyc(2);
    chk({6'h00, lse, por}, 8'h01, "off after power up");
    wr(16'h1234, 8'hff);
    rd(16'h1234, 8'h00, "unmapped read");
    rd(`PSS_ADDR_WAKE_CTL, `PSS_WAKE_CTL_RST, "wake ctl reset");
    press <= 1'b1;
    cyc(10);
    press <= 1'b0;
    cyc(40);
    chk({7'h00, lse}, 8'h00, "short press ignored");
    press <= 1'b1;
    wait_on(lse, 1'b1, 200);
    chk({7'h00, por}, 8'h01, "reset held on turn on");
    press <= 1'b0;
    cyc(40);
    $display("test power on done");
    press <= 1'b1;
    wait_on(shdn, 1'b1, 200);
    press <= 1'b0;
    cyc(40);
    rd(`PSS_ADDR_STATUS, stat(1, 1, 0, 1, 0, 0), "request latched");
    card_active <= 1'b1;
    wr(`PSS_ADDR_CARD_CTL, 8'h02);
    wait_on(card_dea, 1'b1, 10);
    card_active <= 1'b0;
    wait_on(lse, 1'b0, 20);
    chk({7'h00, shdn}, 8'h00, "request cleared off");
    $display("test shutdown done");
    bus_supply <= 1'b1;
    wait_on(lse, 1'b1, 20);
    cyc(30);
    chk({5'h00, bus_sw, bat_sw, byp}, 8'h05, "bus selected, bypass");
    press <= 1'b1;
    cyc(60);
    press <= 1'b0;
    wr(`PSS_ADDR_CARD_CTL, 8'h02);
    cyc(20);
    chk({6'h00, lse, shdn}, 8'h02, "bus keeps on");
    bus_supply <= 1'b0;
    cyc(20);
    chk({5'h00, bus_sw, bat_sw, lse}, 8'h03, "battery takeover");
    rd(`PSS_ADDR_STATUS, stat(1, 0, 0, 1, 0, 0), "status on battery");
    $display("test supplies done");
    n = $random(seed);
    wr(`PSS_ADDR_MISC0, {6'h00, n[1:0]});
    rd(`PSS_ADDR_MISC0, {6'h00, n[1:0]}, "misc0 readback");
    chk({6'h00, card_ck, kp_ck}, {6'h00, n[1:0]}, "individual clock off");
    wr(`PSS_ADDR_WAKE_CTL, {n[3], 5'h00, n[2], 1'b0});
    rd(`PSS_ADDR_WAKE_CTL, {n[3], 5'h00, n[2], 1'b0}, "wake ctl readback");
    rd(`PSS_ADDR_WAKE_CTL, {6'h00, n[2], 1'b0}, "route cleared by read");
    $display("test register fields done");
    for (int k = 0; k < 3; k++) begin
      wr(`PSS_ADDR_WAKE_CTL, 8'h80);
      wr(`PSS_ADDR_MISC0, 8'h80);
      wait_on(gate, 1'b1, 40);
      chk({5'h00, ana, pwr_off, lse}, 8'h03, "standby halts");
      chk({6'h00, card_ck, kp_ck}, 8'h03, "power-down overrides clock bits");
      n = {$random(seed)} % 16;
      cyc(n);
      irq[k] <= 1'b1;
      cyc(2);
      irq[k] <= 1'b0;
      wait_on(gate, 1'b0, 10);
      cyc(6);
      wait_on(eint, 1'b1, 600);
      rd(`PSS_ADDR_WAKE_CTL, 8'h80, "route before read");
      rd(`PSS_ADDR_WAKE_CTL, 8'h00, "route after read");
      chk({7'h00, eint}, 8'h00, "wake interrupt cleared");
    end
    $display("test standby done");
    press <= 1'b1;
    wait_on(shdn, 1'b1, 200);
    press <= 1'b0;
    wr(`PSS_ADDR_MISC0, 8'h80);
    wait_on(lse, 1'b0, 60);
    chk({7'h00, conv}, 8'h00, "converter off");
    $display("test power down off done");
    print_verdict();
  end
endmodule // pss_top_tb
